// ==== cco_exec.sv ====
// Execution sequencer for call, byte clear, watchdog clear and byte invert
// Functional notes
// - A call first pushes PC plus one onto the return stack.
// - Call then loads 13-bit target into PC, takes two cycles, flags untouched.
// - Byte clear writes zero to addressed byte in one cycle, flags untouched.
// - Watchdog clear zeroes the watchdog counter in one cycle, flags untouched.
// - Invert with destination 0 puts inverted byte into accumulator only.
// - Invert with destination 1 writes inverted byte back, accumulator kept, one cycle.
module cco_exec
    import cco_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire logic              OP_VALID,
    input  wire logic [2:0]        OP_SEL,
    input  wire logic [PC_W-1:0]   OP_TARGET,
    input  wire logic [ADDR_W-1:0] OP_ADDR,
    input  wire logic              OP_DEST,
    input  wire logic [DATA_W-1:0] MEM_RDATA,
    input  wire logic              FLAG_Z_IN,
    output logic                   OP_BUSY,
    output logic                   OP_DONE,
    output logic [PC_W-1:0]        PC,
    output logic                   STACK_PUSH,
    output logic [PC_W-1:0]        STACK_DATA,
    output logic                   MEM_WE,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output logic [DATA_W-1:0]      MEM_WDATA,
    output logic [DATA_W-1:0]      ACC,
    output logic                   FLAG_Z,
    output logic                   WDT_CLEAR
);
    // Whole block state: one register, one next-state copy
    typedef struct packed {
        // Sequencer and program flow
        cco_state_t        state;
        logic [PC_W-1:0]   pc;
        logic [PC_W-1:0]   target;
        logic              busy;
        logic              done;
        logic              push;
        logic [PC_W-1:0]   push_data;
        // Data side
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] acc;
        logic              flag_z;
        logic              wdt_clr;
    } cco_regs_t;

    cco_regs_t         regs_ff;
    cco_regs_t         nxt_regs;
    cco_op_t           op;
    logic [DATA_W-1:0] alu_result;
    logic              alu_zero;

    // Idle, zeroed state; the reset branch loads only this constant
    localparam cco_regs_t REGS_RST = '{
        state:     CCO_ST_IDLE,
        pc:        PC_RST,
        target:    PC_RST,
        busy:      1'b0,
        done:      1'b0,
        push:      1'b0,
        push_data: PC_RST,
        we:        1'b0,
        addr:      '0,
        wdata:     BYTE_ZERO,
        acc:       ACC_RST,
        flag_z:    1'b0,
        wdt_clr:   1'b0
    };

    // Sequential successor; wraps silently at the top of program space
    function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc_now);
        return pc_now + PC_ONE;
    endfunction : pc_inc

    // Spare select codes fold to no operation, never to an out-of-range enum
    function automatic cco_op_t decode_op(input logic [2:0] sel);
        cco_op_t dec;
        case (sel)
            3'h1:    dec = CCO_OP_CALL;
            3'h2:    dec = CCO_OP_CLEAR_BYTE;
            3'h3:    dec = CCO_OP_WDT_CLEAR;
            3'h4:    dec = CCO_OP_INVERT;
            default: dec = CCO_OP_NONE;
        endcase
        return dec;
    endfunction : decode_op

    // First call cycle: return address leaves before the PC moves
    function automatic cco_regs_t start_call(input cco_regs_t       nxt,
                                             input logic [PC_W-1:0] pc_now,
                                             input logic [PC_W-1:0] tgt);
        cco_regs_t r;
        r           = nxt;
        r.push      = 1'b1;
        r.push_data = pc_inc(pc_now);
        r.target    = tgt;
        r.busy      = 1'b1;
        r.state     = CCO_ST_CALL2;
        return r;
    endfunction : start_call

    // Tail shared by every one-cycle instruction
    function automatic cco_regs_t retire_one(input cco_regs_t       nxt,
                                             input logic [PC_W-1:0] pc_now);
        cco_regs_t r;
        r      = nxt;
        r.done = 1'b1;
        r.pc   = pc_inc(pc_now);
        return r;
    endfunction : retire_one

    // Result goes to exactly one place; the zero flag follows it either way
    function automatic cco_regs_t invert_step(input cco_regs_t         nxt,
                                              input logic              dest_mem,
                                              input logic [DATA_W-1:0] res,
                                              input logic              res_zero);
        cco_regs_t r;
        r        = nxt;
        r.flag_z = res_zero;
        if (dest_mem) begin
            r.we    = 1'b1;
            r.wdata = res;
        end else begin
            // Memory untouched: no write strobe on this path
            r.acc = res;
        end
        return r;
    endfunction : invert_step

    assign op = decode_op(OP_SEL);

    // Clear reuses the invert unit with its output forced to zero
    cco_alu u_alu (
        .invert  (op == CCO_OP_INVERT),
        .operand (MEM_RDATA),
        .result  (alu_result),
        .is_zero (alu_zero)
    );

    always_comb begin
        nxt_regs         = regs_ff;
        // Strobes default low so each lasts exactly one cycle
        nxt_regs.done    = 1'b0;
        nxt_regs.push    = 1'b0;
        nxt_regs.we      = 1'b0;
        nxt_regs.wdt_clr = 1'b0;
        // Flag follows the core unless this block owns it this cycle
        nxt_regs.flag_z  = FLAG_Z_IN;
        case (regs_ff.state)
            CCO_ST_IDLE: begin
                nxt_regs.busy = 1'b0;
                // Requests are only looked at here, so a busy call refuses them
                if (OP_VALID) begin
                    case (op)
                        CCO_OP_CALL: begin
                            nxt_regs = start_call(nxt_regs, regs_ff.pc, OP_TARGET);
                        end
                        CCO_OP_CLEAR_BYTE: begin
                            nxt_regs.we    = 1'b1;
                            nxt_regs.addr  = OP_ADDR;
                            nxt_regs.wdata = alu_result;
                            nxt_regs       = retire_one(nxt_regs, regs_ff.pc);
                        end
                        CCO_OP_WDT_CLEAR: begin
                            nxt_regs.wdt_clr = 1'b1;
                            nxt_regs         = retire_one(nxt_regs, regs_ff.pc);
                        end
                        CCO_OP_INVERT: begin
                            nxt_regs.addr = OP_ADDR;
                            nxt_regs      = invert_step(nxt_regs, OP_DEST, alu_result, alu_zero);
                            nxt_regs      = retire_one(nxt_regs, regs_ff.pc);
                        end
                        default: begin
                            // Spare codes: no effect and no completion
                        end
                    endcase
                end
            end
            CCO_ST_CALL2: begin
                // Second cycle of the call: jump, flags left alone
                // A request arriving now is dropped; the caller must watch OP_BUSY
                nxt_regs.pc    = regs_ff.target;
                nxt_regs.busy  = 1'b0;
                nxt_regs.done  = 1'b1;
                nxt_regs.state = CCO_ST_IDLE;
            end
            default: begin
                nxt_regs.state = CCO_ST_IDLE;
                nxt_regs.busy  = 1'b0;
            end
        endcase
    end

    // One register for all state, so every output moves on the same edge
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            regs_ff <= REGS_RST;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // Outputs are register bits, so the datapath never sees decode glitches
    assign OP_BUSY    = regs_ff.busy;
    assign OP_DONE    = regs_ff.done;
    assign PC         = regs_ff.pc;
    assign STACK_PUSH = regs_ff.push;
    assign STACK_DATA = regs_ff.push_data;
    assign MEM_WE     = regs_ff.we;
    assign MEM_ADDR   = regs_ff.addr;
    assign MEM_WDATA  = regs_ff.wdata;
    assign ACC        = regs_ff.acc;
    assign FLAG_Z     = regs_ff.flag_z;
    assign WDT_CLEAR  = regs_ff.wdt_clr;
endmodule : cco_exec

// ==== cco_pkg.sv ====
// Shared constants and types for the call/clear/complement execution block
package cco_pkg;
    localparam int PC_W         = 13;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 8;
    localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [PC_W-1:0]   PC_ONE   = 13'h0001;
    localparam logic [1:0]        CALL_CYCLES = 2'h2;

    // Operation select from the instruction decoder
    typedef enum logic [2:0] {
        CCO_OP_NONE       = 3'b000,
        CCO_OP_CALL       = 3'b001,
        CCO_OP_CLEAR_BYTE = 3'b010,
        CCO_OP_WDT_CLEAR  = 3'b011,
        CCO_OP_INVERT     = 3'b100
    } cco_op_t;

    typedef enum logic [1:0] {
        CCO_ST_IDLE  = 2'b00,
        CCO_ST_CALL2 = 2'b01
    } cco_state_t;
endpackage : cco_pkg

// ==== cco_alu.sv ====
// Single-operand result unit: clear or invert, with zero detection
module cco_alu
    import cco_pkg::*;
(
    input  wire logic              invert,
    input  wire logic [DATA_W-1:0] operand,
    output logic      [DATA_W-1:0] result,
    output logic                   is_zero
);
    always_comb begin
        result  = invert ? ~operand : BYTE_ZERO;
        is_zero = (result == BYTE_ZERO);
    end
endmodule : cco_alu

// ==== cco_exec_checker.sv ====
// Concurrent property checks on the execution sequencer ports
module cco_exec_checker
    import cco_pkg::*;
(
    input wire logic              MCLK,
    input wire logic              RST_B,
    input wire logic              OP_VALID,
    input wire logic [2:0]        OP_SEL,
    input wire logic [PC_W-1:0]   OP_TARGET,
    input wire logic [ADDR_W-1:0] OP_ADDR,
    input wire logic              OP_DEST,
    input wire logic [DATA_W-1:0] MEM_RDATA,
    input wire logic              FLAG_Z_IN,
    input wire logic              OP_BUSY,
    input wire logic              OP_DONE,
    input wire logic [PC_W-1:0]   PC,
    input wire logic              STACK_PUSH,
    input wire logic [PC_W-1:0]   STACK_DATA,
    input wire logic              MEM_WE,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic [DATA_W-1:0] MEM_WDATA,
    input wire logic [DATA_W-1:0] ACC,
    input wire logic              FLAG_Z,
    input wire logic              WDT_CLEAR
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // Request accepted only while idle
    sequence s_go(logic [2:0] s);
        OP_VALID && !OP_BUSY && OP_SEL == s;
    endsequence
    chk_call_push: assert property (s_go(3'h1) |=> STACK_PUSH && STACK_DATA == $past(PC) + 13'h1)
        else $error("call push wrong");
    chk_call_jump: assert property (s_go(3'h1) |=> OP_BUSY ##1 PC == $past(OP_TARGET, 2))
        else $error("call target wrong");
    chk_clear_zero: assert property (s_go(3'h2) |=> MEM_WE && MEM_WDATA == 8'h00)
        else $error("byte clear wrong");
    chk_wdt_pulse: assert property (s_go(3'h3) |=> WDT_CLEAR && !MEM_WE)
        else $error("watchdog clear missing");
    chk_inv_acc: assert property (s_go(3'h4) ##0 !OP_DEST |=> ACC == ~$past(MEM_RDATA) && !MEM_WE)
        else $error("invert to acc wrong");
    chk_inv_mem: assert property (s_go(3'h4) ##0 OP_DEST |=> MEM_WE && $stable(ACC)
        && MEM_WDATA == ~$past(MEM_RDATA) && MEM_ADDR == $past(OP_ADDR))
        else $error("invert to memory wrong");
    chk_inv_zflag: assert property (s_go(3'h4) |=> FLAG_Z == ($past(MEM_RDATA) == 8'hff))
        else $error("invert zero flag wrong");
    // Call: push while busy, then jump with done and busy gone
    sequence s_call_tail;
        STACK_PUSH && OP_BUSY && !OP_DONE ##1 OP_DONE && !OP_BUSY && !STACK_PUSH;
    endsequence
    chk_call_steps: assert property (s_go(3'h1) |=> s_call_tail)
        else $error("call sequence wrong");
    chk_call_flags: assert property (s_go(3'h1) |=>
        FLAG_Z == $past(FLAG_Z_IN) ##1 FLAG_Z == $past(FLAG_Z_IN))
        else $error("call changed zero flag");
    chk_flag_hold: assert property (OP_VALID && !OP_BUSY
        && (OP_SEL == 3'h2 || OP_SEL == 3'h3) |=> FLAG_Z == $past(FLAG_Z_IN))
        else $error("clear changed zero flag");
    chk_clear_addr: assert property (s_go(3'h2) |=> MEM_ADDR == $past(OP_ADDR) && OP_DONE)
        else $error("byte clear address wrong");
    chk_busy_refuse: assert property (OP_BUSY |=>
        !STACK_PUSH && !MEM_WE && !WDT_CLEAR && $stable(ACC))
        else $error("request taken while busy");
endmodule : cco_exec_checker

bind cco_exec cco_exec_checker u_chk (.*);

// ==== cco_exec_tb.sv ====
// Self-checking bench for the execution sequencer
module cco_exec_tb import cco_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic            MCLK = '0, RST_B = '0, OP_VALID = '0, OP_DEST = '0, FLAG_Z_IN = '0;
    logic [2:0]      OP_SEL = '0;
    logic [PC_W-1:0] OP_TARGET = '0, PC, STACK_DATA, epc = '0;
    logic [7:0]      OP_ADDR = '0, MEM_RDATA = '0, ACC, MEM_WDATA, MEM_ADDR, eacc = '0;
    logic            OP_BUSY, OP_DONE, STACK_PUSH, MEM_WE, FLAG_Z, WDT_CLEAR;
    logic [20:0]     q[$];
    int              err_count = 0, n_tests = 0, seed = 32'h18c50841;
    always #5 MCLK = ~MCLK;
    cco_exec dut (.MCLK(MCLK), .RST_B(RST_B), .OP_VALID(OP_VALID), .OP_SEL(OP_SEL),
        .OP_TARGET(OP_TARGET), .OP_ADDR(OP_ADDR), .OP_DEST(OP_DEST), .MEM_RDATA(MEM_RDATA),
        .FLAG_Z_IN(FLAG_Z_IN), .OP_BUSY(OP_BUSY), .OP_DONE(OP_DONE), .PC(PC),
        .STACK_PUSH(STACK_PUSH), .STACK_DATA(STACK_DATA), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .ACC(ACC), .FLAG_Z(FLAG_Z), .WDT_CLEAR(WDT_CLEAR));
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] pc_acc exp %h got %h", exp, got);
        end
    endtask : chk
    task automatic op(input logic [2:0] s, input logic [12:0] t, input logic [7:0] r, input logic d);
        @(negedge MCLK);
        {OP_VALID, OP_SEL, OP_TARGET, MEM_RDATA, OP_DEST} = {1'h1, s, t, r, d};
        OP_ADDR = r ^ 8'h5a;
        FLAG_Z_IN = ~d;
        epc = (s == 3'h1) ? t : epc + 13'h1;
        if (s == 3'h4 && !d) eacc = ~r;
        q.push_back({epc, eacc});
        if (s == 3'h1) begin
            // Busy cycle: an invert here must be ignored
            @(negedge MCLK);
            {OP_SEL, OP_DEST} = 4'h8;
        end
    endtask : op
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    always @(posedge MCLK) begin
        #1;
        if (OP_DONE === 1'h1) begin
            if (q.size() == 0) chk(21'h0, 21'h1fffff);
            else chk({PC, ACC}, q.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge MCLK);
        @(negedge MCLK) RST_B = 1'h1;
        op(3'h4, 13'h0, 8'hff, 1'h0);
        op(3'h1, 13'h1fff, 8'h00, 1'h0);
        for (int i = 0; i < 80; i++)
            op(3'($unsigned($random(seed)) % 4 + 1), 13'($random(seed)), 8'($random(seed)),
               1'($random(seed)));
        // Spare select code: no completion may follow it
        @(negedge MCLK) OP_SEL = 3'h6;
        @(negedge MCLK) OP_VALID = 1'h0;
        for (int i = 0; i < 9 && q.size() > 0; i++) @(posedge MCLK);
        if (q.size() > 0) err_count++;
        print_verdict();
    end
endmodule : cco_exec_tb
